/* File: sfp_pkg.sv */
// constants, encodings and states of the serial flash command interpreter
// assumes nothing of its surroundings; imported by serial_flash_program_commands
package sfp_pkg;

    // command bytes
    localparam logic [7:0] CMD_PAGE_READ    = 8'hFF;
    localparam logic [7:0] CMD_PAGE_PROG    = 8'h41;
    localparam logic [7:0] CMD_ERASE_ALL    = 8'hA7;
    localparam logic [7:0] ERASE_CONFIRM    = 8'hD0;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ID_CHECK     = 8'hF5;
    localparam logic [7:0] CMD_DOWNLOAD     = 8'hFA;
    localparam logic [7:0] CMD_VERSION      = 8'hFB;
    localparam logic [7:0] CMD_BOOT_READ    = 8'hFC;

    // transfer counts
    localparam logic [8:0] PAGE_BYTES    = 9'h100;
    localparam logic [8:0] STATUS_BYTES  = 9'h002;
    localparam logic [8:0] VERSION_BYTES = 9'h008;
    localparam logic [7:0] ID_BYTES      = 8'h07;
    localparam logic [2:0] BITS_PER_BYTE = 3'h7;

    // header bytes after each command byte
    localparam logic [2:0] HDR_ADDR     = 3'h2;
    localparam logic [2:0] HDR_ERASE    = 3'h1;
    localparam logic [2:0] HDR_DOWNLOAD = 3'h3;
    localparam logic [2:0] HDR_ID       = 3'h4;

    // flash status byte fields
    localparam int SEQ_READY_BIT  = 7;
    localparam int ERASE_ERR_BIT  = 5;
    localparam int PROG_ERR_BIT   = 4;
    localparam int BIT_THREE      = 3;
    // link status byte fields
    localparam int BOOT_DONE_BIT  = 7;
    localparam int CSUM_MATCH_BIT = 4;
    localparam int ID_STATE_LSB   = 2;

    // id check result codes
    localparam logic [1:0] ID_NOT_VERIFIED = 2'h0;
    localparam logic [1:0] ID_MISMATCH     = 2'h1;
    localparam logic [1:0] ID_VERIFIED     = 2'h3;

    // reset values
    localparam logic       READY_N_RESET = 1'b0;
    localparam logic [7:0] TX_RESET      = 8'h00;

    typedef enum logic [3:0] {
        ST_CMD, ST_HDR, ST_START, ST_LOAD, ST_WAIT, ST_PRESENT, ST_SEND,
        ST_PROG, ST_BUSY, ST_CLEAR, ST_DOWNLOAD, ST_CHECK, ST_IDCODE, ST_IDDONE
    } cmd_state_t;

endpackage

/* File: serial_flash_program_commands.sv */
// serial programming command interpreter: bit engine, command decode, flash/ram strobes
// assumes a flash array and ram beside it on clk_sys; sclk and rxd come from pins
`timescale 1ns/100ps
`default_nettype none

// three-stage pin synchroniser with agreement filter
module sfp_pin_sync (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s1    <= 1'b1;
            s2    <= 1'b1;
            s3    <= 1'b1;
            level <= 1'b1;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

// What this block does
// - page read takes middle, high address; returns 256 bytes lowest first from byte four.
// - page program takes middle, high address then 256 bytes; page written automatically.
// - after page program, ready stays high until the next page can be taken.
// - erase-all starts only when the second byte is the confirm code.
// - ready stays high during whole erase, drops at end; result in status.
// - read status returns flash status then link status byte.
// - clear status clears error bits three to five of flash status.
// - ready goes high to low once clear status is done.
// - without verified id only status, id check and version are accepted.
// - a blank flash accepts every command regardless of id state.
// - download takes size low, high, checksum, then program bytes into ram.
// - program bytes are summed, compared with checksum, program run on match.
// - version command returns eight ascii characters from the second byte.
// - boot-area read returns 256-byte boot page lowest first from byte four.
// - no single-block erase exists; only whole-array erase.
// - commands and write data arrive on rxd; only read data leaves on txd.
// - bytes are lsb first, sampled on sclk rise, changed on sclk fall.
// - ready is high while busy; programmer waits for low before next byte.
// - id check takes three address bytes, a count and up to seven id bytes.
// - flash status bit7 ready, bit5 erase error, bit4 program error.
module serial_flash_program_commands #(
    parameter logic [63:0] VERSION_TEXT = 64'h5645_5231_2E30_3020  // arbitrary text
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic                 sclk,
    input  wire logic                 rxd,
    output logic                      txd,
    output logic                      transferReadyN,
    input  wire logic                 flashBlank,
    input  wire logic [55:0]          idStored,
    output logic [23:0]               memAddr,
    output logic                      memBoot,
    output logic                      memRead,
    input  wire logic [7:0]           memRdata,
    output logic                      memWrite,
    output logic [7:0]                memWdata,
    output logic                      progStart,
    output logic                      eraseStart,
    input  wire logic                 flashDone,
    input  wire logic                 flashError,
    output logic                      ramWrite,
    output logic [15:0]               ramAddr,
    output logic [7:0]                ramData,
    output logic                      runProgram
);
    import sfp_pkg::*;

    logic                 sclkLevel;
    logic                 rxdLevel;
    logic                 sclkLast;
    logic [2:0]           bitCnt;
    logic [7:0]           rxShift;
    logic                 byteDone;
    logic [7:0]           txShift;
    logic                 arm;
    logic [7:0]           armByte;
    cmd_state_t           state;
    logic [7:0]           cmd;
    logic [2:0]           hdrNeed;
    logic [2:0]           hdrCnt;
    logic [7:0]           hdr [0:3];
    logic [8:0]           count;
    logic [15:0]          dlLeft;
    logic [15:0]          ramPtr;
    logic [7:0]           sum;
    logic [7:0]           idLeft;
    logic [2:0]           idIdx;
    logic                 idOk;
    logic [1:0]           idState;
    logic                 eraseErrorFlag;
    logic                 programErrorFlag;
    logic                 statusBitThree;
    logic                 checksumMatch;
    logic                 bootUpdated;

    ////////////////////////////////////////////////////////////////////////////////
    // pin capture

    sfp_pin_sync sclkSync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pin     (sclk),
        .level   (sclkLevel)
    );

    sfp_pin_sync rxdSync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pin     (rxd),
        .level   (rxdLevel)
    );

    wire sclkRise = sclkLevel && !sclkLast;
    wire sclkFall = !sclkLevel && sclkLast;

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    wire sequencerReadyFlag = (state != ST_BUSY);
    wire [7:0] flashStatusByte = {sequencerReadyFlag, 1'b0, eraseErrorFlag, programErrorFlag,
                                  statusBitThree, 3'h0};
    wire [7:0] linkStatusByte  = {bootUpdated, 2'h0, checksumMatch, idState, 2'h0};

    wire idVerified = (idState == ID_VERIFIED);
    wire freeCmd    = (rxShift == CMD_READ_STATUS) || (rxShift == CMD_ID_CHECK)
                   || (rxShift == CMD_VERSION);
    // no block-erase code is decoded at all
    wire knownCmd   = freeCmd || (rxShift == CMD_PAGE_READ) || (rxShift == CMD_PAGE_PROG)
                   || (rxShift == CMD_ERASE_ALL) || (rxShift == CMD_CLEAR_STATUS)
                   || (rxShift == CMD_DOWNLOAD) || (rxShift == CMD_BOOT_READ);
    wire openCmd    = knownCmd && (freeCmd || idVerified || flashBlank);
    wire [2:0] hdrFor = (rxShift == CMD_ERASE_ALL) ? HDR_ERASE :
                        (rxShift == CMD_DOWNLOAD)  ? HDR_DOWNLOAD :
                        (rxShift == CMD_ID_CHECK)  ? HDR_ID : HDR_ADDR;

    wire [5:0] versionLsb = {count[2:0], 3'h0} - 6'h08;
    wire [7:0] versionChar = VERSION_TEXT[versionLsb +: 8];
    wire [7:0] loadByte = (cmd == CMD_READ_STATUS) ?
                              ((count == STATUS_BYTES) ? flashStatusByte : linkStatusByte) :
                          (cmd == CMD_VERSION) ? versionChar : memRdata;
    wire isRead   = (cmd == CMD_PAGE_READ) || (cmd == CMD_BOOT_READ);
    wire [7:0] idByte = idStored[{idIdx, 3'h0} +: 8];
    wire idInRange = (hdr[3] != 8'h00) && (hdr[3] <= ID_BYTES);
    wire [15:0] dlSize = {hdr[1], hdr[0]};

    ////////////////////////////////////////////////////////////////////////////////
    // bit engine

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sclkLast <= 1'b1;
            bitCnt   <= 3'h0;
            rxShift  <= 8'h00;
            byteDone <= 1'b0;
        end else begin
            sclkLast <= sclkLevel;
            byteDone <= 1'b0;
            if (sclkRise) begin
                rxShift <= {rxdLevel, rxShift[7:1]};
                bitCnt  <= bitCnt + 3'h1;
                byteDone <= (bitCnt == BITS_PER_BYTE);
            end
        end
    end

    // bit0 goes out on the fall before the first rise, since sclk idles high
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            txShift <= TX_RESET;
            txd     <= 1'b1;
        end else if (arm) begin
            txShift <= armByte;
        end else if (sclkFall) begin
            txd     <= txShift[0];
            txShift <= {1'b0, txShift[7:1]};
        end
    end

    // the start of a byte wins over a late arm, so busy is never lost
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            transferReadyN <= READY_N_RESET;
        end else if (sclkRise && bitCnt == 3'h0) begin
            transferReadyN <= 1'b1;
        end else if (arm) begin
            transferReadyN <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command sequencer

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state            <= ST_CMD;
            cmd              <= 8'h00;
            hdrNeed          <= 3'h0;
            hdrCnt           <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                hdr[i] <= 8'h00;
            end
            count            <= 9'h000;
            dlLeft           <= 16'h0000;
            ramPtr           <= 16'h0000;
            sum              <= 8'h00;
            idLeft           <= 8'h00;
            idIdx            <= 3'h0;
            idOk             <= 1'b0;
            idState          <= ID_NOT_VERIFIED;
            eraseErrorFlag   <= 1'b0;
            programErrorFlag <= 1'b0;
            statusBitThree   <= 1'b0;
            checksumMatch    <= 1'b0;
            bootUpdated      <= 1'b0;
            arm              <= 1'b0;
            armByte          <= 8'h00;
            memAddr          <= 24'h00_0000;
            memBoot          <= 1'b0;
            memRead          <= 1'b0;
            memWrite         <= 1'b0;
            memWdata         <= 8'h00;
            progStart        <= 1'b0;
            eraseStart       <= 1'b0;
            ramWrite         <= 1'b0;
            ramAddr          <= 16'h0000;
            ramData          <= 8'h00;
            runProgram       <= 1'b0;
        end else begin
            arm        <= 1'b0;
            armByte    <= 8'h00;
            memRead    <= 1'b0;
            memWrite   <= 1'b0;
            progStart  <= 1'b0;
            eraseStart <= 1'b0;
            ramWrite   <= 1'b0;
            runProgram <= 1'b0;
            if (memWrite) begin
                memAddr[7:0] <= memAddr[7:0] + 8'h01;
            end
            unique case (state)
                ST_CMD: begin
                    if (byteDone) begin
                        cmd     <= rxShift;
                        hdrCnt  <= 3'h0;
                        hdrNeed <= hdrFor;
                        if (!openCmd) begin
                            arm <= 1'b1;
                        end else if (rxShift == CMD_READ_STATUS) begin
                            count <= STATUS_BYTES;
                            state <= ST_LOAD;
                        end else if (rxShift == CMD_VERSION) begin
                            count <= VERSION_BYTES;
                            state <= ST_LOAD;
                        end else if (rxShift == CMD_CLEAR_STATUS) begin
                            state <= ST_CLEAR;
                        end else begin
                            arm   <= 1'b1;
                            state <= ST_HDR;
                        end
                    end
                end
                ST_HDR: begin
                    if (byteDone) begin
                        hdr[hdrCnt[1:0]] <= rxShift;
                        hdrCnt <= hdrCnt + 3'h1;
                        if (hdrCnt == hdrNeed - 3'h1) begin
                            state <= ST_START;
                        end else begin
                            arm <= 1'b1;
                        end
                    end
                end
                ST_START: begin
                    // high address byte goes to memAddr[23:16] as received and is not checked
                    memAddr <= {hdr[1], hdr[0], 8'h00};
                    memBoot <= (cmd == CMD_BOOT_READ);
                    count   <= PAGE_BYTES;
                    sum     <= 8'h00;
                    ramPtr  <= 16'h0000;
                    dlLeft  <= dlSize;
                    idLeft  <= hdr[3];
                    idIdx   <= 3'h0;
                    idOk    <= idInRange;
                    if (isRead) begin
                        state <= ST_LOAD;
                    end else if (cmd == CMD_PAGE_PROG) begin
                        arm   <= 1'b1;
                        state <= ST_PROG;
                    end else if (cmd == CMD_ERASE_ALL) begin
                        if (hdr[0] == ERASE_CONFIRM) begin
                            eraseStart <= 1'b1;
                            state      <= ST_BUSY;
                        end else begin
                            arm   <= 1'b1;
                            state <= ST_CMD;
                        end
                    end else if (cmd == CMD_DOWNLOAD) begin
                        if (dlSize == 16'h0000) begin
                            state <= ST_CHECK;
                        end else begin
                            arm   <= 1'b1;
                            state <= ST_DOWNLOAD;
                        end
                    end else begin
                        if (hdr[3] == 8'h00) begin
                            state <= ST_IDDONE;
                        end else begin
                            arm   <= 1'b1;
                            state <= ST_IDCODE;
                        end
                    end
                end
                ST_LOAD: begin
                    memRead <= isRead;
                    state   <= ST_WAIT;
                end
                ST_WAIT: begin
                    state <= ST_PRESENT;
                end
                ST_PRESENT: begin
                    arm     <= 1'b1;
                    armByte <= loadByte;
                    state   <= ST_SEND;
                end
                ST_SEND: begin
                    if (byteDone) begin
                        count        <= count - 9'h001;
                        memAddr[7:0] <= memAddr[7:0] + 8'h01;
                        if (count == 9'h001) begin
                            arm   <= 1'b1;
                            state <= ST_CMD;
                        end else begin
                            state <= ST_LOAD;
                        end
                    end
                end
                ST_PROG: begin
                    if (byteDone) begin
                        memWrite <= 1'b1;
                        memWdata <= rxShift;
                        count    <= count - 9'h001;
                        if (count == 9'h001) begin
                            progStart <= 1'b1;
                            state     <= ST_BUSY;
                        end else begin
                            arm <= 1'b1;
                        end
                    end
                end
                ST_BUSY: begin
                    // ready stays high until the array reports completion
                    if (flashDone) begin
                        if (cmd == CMD_ERASE_ALL) begin
                            eraseErrorFlag <= eraseErrorFlag || flashError;
                        end else begin
                            programErrorFlag <= programErrorFlag || flashError;
                        end
                        arm   <= 1'b1;
                        state <= ST_CMD;
                    end
                end
                ST_CLEAR: begin
                    eraseErrorFlag   <= 1'b0;
                    programErrorFlag <= 1'b0;
                    statusBitThree   <= 1'b0;
                    arm              <= 1'b1;
                    state            <= ST_CMD;
                end
                ST_DOWNLOAD: begin
                    if (byteDone) begin
                        ramWrite <= 1'b1;
                        ramData  <= rxShift;
                        ramAddr  <= ramPtr;
                        ramPtr   <= ramPtr + 16'h0001;
                        sum      <= sum + rxShift;
                        dlLeft   <= dlLeft - 16'h0001;
                        if (dlLeft == 16'h0001) begin
                            state <= ST_CHECK;
                        end else begin
                            arm <= 1'b1;
                        end
                    end
                end
                ST_CHECK: begin
                    checksumMatch <= (sum == hdr[2]);
                    if (sum == hdr[2]) begin
                        runProgram  <= 1'b1;
                        bootUpdated <= 1'b1;
                    end
                    arm   <= 1'b1;
                    state <= ST_CMD;
                end
                ST_IDCODE: begin
                    if (byteDone) begin
                        if (idLeft <= ID_BYTES && rxShift != idByte) begin
                            idOk <= 1'b0;
                        end
                        idIdx  <= idIdx + 3'h1;
                        idLeft <= idLeft - 8'h01;
                        if (idLeft == 8'h01) begin
                            state <= ST_IDDONE;
                        end else begin
                            arm <= 1'b1;
                        end
                    end
                end
                ST_IDDONE: begin
                    idState <= idOk ? ID_VERIFIED : ID_MISMATCH;
                    arm     <= 1'b1;
                    state   <= ST_CMD;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: sfp_props.sv */
// port assertions of the serial flash command interpreter
// assumes a bind from the bench top file
`timescale 1ns/100ps
`default_nettype none
module sfp_props (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        txd,
    input wire logic        transferReadyN,
    input wire logic [23:0] memAddr,
    input wire logic        memBoot,
    input wire logic        memRead,
    input wire logic        memWrite,
    input wire logic        progStart,
    input wire logic        eraseStart,
    input wire logic        flashDone,
    input wire logic        ramWrite,
    input wire logic        runProgram
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_reset_vals: assert property (disable iff (1'b0) reset |=> !transferReadyN && txd
        && !memWrite && !eraseStart && !progStart) else $error("bad reset value");
    a_prog_last: assert property (progStart |-> memWrite)
        else $error("program start without write");
    a_start_busy: assert property ((progStart || eraseStart) |=> transferReadyN [*2])
        else $error("ready at flash start");
    a_done_ready: assert property (flashDone && transferReadyN |-> ##[1:3] !transferReadyN)
        else $error("ready late after done");
    a_addr_step: assert property (memWrite |=> memAddr[7:0] == $past(memAddr[7:0]) + 8'h01)
        else $error("address not stepped");
    a_read_pulse: assert property (memRead |=> !memRead)
        else $error("read strobe too long");
    a_boot_ro: assert property (memBoot |-> !memWrite && !progStart && !eraseStart)
        else $error("write during boot read");
    a_run_clean: assert property (runProgram |-> !ramWrite && !memWrite)
        else $error("run during write");
    c_erase: cover property (eraseStart);
    c_prog: cover property (progStart);
    c_run: cover property (runProgram);
endmodule
`default_nettype wire

/* File: sfp_programmer.sv */
// serial programmer model: drives sclk and rxd, reads txd
// assumes clk_sys only as a time base
`timescale 1ns/100ps
`default_nettype none
module sfp_programmer (
    input  wire logic clk_sys,
    output var logic  sclk,
    output var logic  rxd,
    input  wire logic txd,
    input  wire logic transferReadyN
);
    int hangs = 0;
    initial begin
        sclk = 1'b1;
        rxd = 1'b0;
    end
    // txd read late in the high phase: it stands until the next fall
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        while (transferReadyN !== 1'b0 && n < 20000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 20000) hangs++;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            sclk <= 1'b0;
            rxd <= d[i];
            repeat (5) @(posedge clk_sys);
            sclk <= 1'b1;
            repeat (5) @(posedge clk_sys);
            q[i] = txd;
        end
        rxd <= ~d[7];
        repeat (5) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* File: tb_serial_flash_program_commands.sv */
// bench of the serial flash command interpreter
// assumes the programmer model and the checker beside it
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_serial_flash_program_commands;
    import sfp_pkg::*;
    localparam logic [63:0] VER = 64'h4142_4344_3031_3233; // arbitrary text
    localparam logic [55:0] IDC = 56'h11_2233_4455_6677;   // arbitrary code
    logic clk_sys = 1'b0, reset = 1'b1, flashBlank = 1'b0, flashDone = 1'b0;
    logic flashError = 1'b0, errSel = 1'b0, sclk, rxd, txd, transferReadyN;
    logic memBoot, memRead, memWrite, progStart, eraseStart, ramWrite, runProgram;
    logic [23:0] memAddr;
    logic [15:0] ramAddr;
    logic [7:0]  memRdata = 8'h00, memWdata, ramData, q, fs, ls;
    int n_errors = 0, total_checks = 0, nRead = 0, nErase = 0, nRun = 0, nRam = 0;
    int wIdx = 0, fc = 0, n0, n1;
    initial forever #4 clk_sys = ~clk_sys;
    serial_flash_program_commands #(.VERSION_TEXT(VER)) u_dut (.clk_sys, .reset, .sclk,
        .rxd, .txd, .transferReadyN, .flashBlank, .idStored(IDC), .memAddr, .memBoot,
        .memRead, .memRdata, .memWrite, .memWdata, .progStart, .eraseStart, .flashDone,
        .flashError, .ramWrite, .ramAddr, .ramData, .runProgram);
    sfp_programmer u_prog (.clk_sys, .sclk, .rxd, .txd, .transferReadyN);
    ////////////////////////////////////////////////////////////////////////////////
    // memory and flash stand-in; done 20 cycles after a start
    function automatic logic [7:0] pat(input logic [23:0] a, input logic b);
        return a[7:0] ^ a[15:8] ^ {b, 7'h00};
    endfunction
    always @(posedge clk_sys) begin
        if (memRead) memRdata <= pat(memAddr, memBoot);
        flashDone <= (fc == 1);
        flashError <= errSel;
        fc <= (progStart || eraseStart) ? 20 : (fc > 0 ? fc - 1 : 0);
        nRead <= nRead + memRead;
        nErase <= nErase + eraseStart;
        nRun <= nRun + runProgram;
        nRam <= nRam + ramWrite;
        if (memWrite) begin
            `CHK("memAddr", {16'h0034, wIdx[7:0]}, memAddr)
            `CHK("memWdata", wIdx[7:0] ^ 8'h5A, memWdata)
            wIdx <= wIdx + 1;
        end
        if (ramWrite) begin
            `CHK("ramAddr", nRam - n1, ramAddr)
            `CHK("ramData", 8'h10 * (nRam - n1 + 1), ramData)
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic x(input logic [7:0] d);
        u_prog.xfer(d, q);
    endtask
    task automatic rdStatus;
        x(CMD_READ_STATUS);
        x(8'h00);
        fs = q;
        x(8'h00);
        ls = q;
    endtask
    task automatic t_refused;
        n0 = nRead;
        n1 = nErase;
        x(CMD_PAGE_READ);
        x(8'h12);
        x(CMD_ERASE_ALL);
        x(ERASE_CONFIRM);
        rdStatus();
        `CHK("fs", 8'h80, fs)
        `CHK("ls", 8'h00, ls)
        `CHK("reads", n0, nRead)
        `CHK("erases", n1, nErase)
    endtask
    task automatic t_version;
        x(CMD_VERSION);
        for (int i = 0; i < 8; i++) begin
            x(8'h00);
            `CHK("version", VER[63-8*i -: 8], q)
        end
    endtask
    task automatic t_erase;
        flashBlank <= 1'b1;
        errSel <= 1'b1;
        n0 = nErase;
        x(CMD_ERASE_ALL);
        x(8'h00);
        x(CMD_ERASE_ALL);
        x(ERASE_CONFIRM);
        rdStatus();
        `CHK("erases", n0 + 1, nErase)
        `CHK("fs erase", 8'hA0, fs)
        x(CMD_CLEAR_STATUS);
        rdStatus();
        `CHK("fs clear", 8'h80, fs)
        flashBlank <= 1'b0;
    endtask
    task automatic idCheck(input logic [55:0] v, input logic [1:0] e);
        x(CMD_ID_CHECK);
        for (int i = 0; i < 3; i++) x(8'h00);
        x(8'h07);
        for (int i = 0; i < 7; i++) x(v[8*i +: 8]);
        rdStatus();
        `CHK("id state", e, ls[3:2])
    endtask
    task automatic t_read(input logic [7:0] c, input logic b);
        n0 = nRead;
        x(c);
        x(8'h12);
        x(8'h00);
        for (int i = 0; i < 256; i++) begin
            x(8'h00);
            `CHK("page data", pat({16'h0012, i[7:0]}, b), q)
        end
        `CHK("reads", n0 + 256, nRead)
    endtask
    task automatic t_prog;
        x(CMD_PAGE_PROG);
        x(8'h34);
        x(8'h00);
        for (int i = 0; i < 256; i++) x(i[7:0] ^ 8'h5A);
        rdStatus();
        `CHK("writes", 256, wIdx)
        `CHK("fs prog", 8'h90, fs)
    endtask
    task automatic t_dl(input logic [7:0] cs, input logic r);
        n0 = nRun;
        n1 = nRam;
        x(CMD_DOWNLOAD);
        x(8'h03);
        x(8'h00);
        x(cs);
        x(8'h10);
        x(8'h20);
        x(8'h30);
        rdStatus();
        `CHK("ram writes", n1 + 3, nRam)
        `CHK("runs", n0 + r, nRun)
        `CHK("match", r, ls[4])
    endtask
    task automatic conclude;
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (8) @(posedge clk_sys);
        t_refused();
        t_version();
        t_erase();
        idCheck({IDC[55:8], ~IDC[7:0]}, 2'h1);
        idCheck(IDC, 2'h3);
        t_read(CMD_PAGE_READ, 1'b0);
        t_read(CMD_BOOT_READ, 1'b1);
        t_prog();
        t_dl(8'h61, 1'b0);
        t_dl(8'h60, 1'b1);
        `CHK("hangs", 0, u_prog.hangs)
        conclude();
    end
    initial begin
        #780000;
        n_errors++;
        conclude();
    end
endmodule
bind serial_flash_program_commands sfp_props u_props (.clk_sys, .reset, .txd, .transferReadyN,
    .memAddr, .memBoot, .memRead, .memWrite, .progStart, .eraseStart, .flashDone, .ramWrite,
    .runProgram);
`default_nettype wire
